// ### verilog/rac_alarm_compare.sv
`timescale 1ns/10ps
`include "rac_consts.svh"

// Behaviour
// - Only enabled alarm registers join comparison
// - Flag sets when all enabled fields match and at least one field is enabled
// - Second alarm: BCD bits 6-0, 00-59
// - Minute alarm: BCD bits 6-0, 00-59
// - Hour alarm: BCD bits 5-0, 00-23
// - Weekday alarm: code bits 2-0, 0-6
// - Day alarm: BCD bits 5-0, 01-31
// - Month alarm: BCD bits 4-0, 01-12
// - Power-on reset clears every enable bit
// - Value fields survive every reset and standby
// - Hour, day bit 6 reads zero
// - Weekday bits 6-3 read zero
// - Month bits 6-5 read zero
// - Writing 0 to control one clears flag; 1 keeps it
// - Interrupt only when flag and enable set
module rac_alarm_compare (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RESET,
    input  wire logic             MANUAL_RESET,
    // Register port
    input  wire logic [3:0]       ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [7:0]       RDATA,
    // Time counters
    input  wire rac_pkg::rac_time_t TIME_NOW,
    // Interrupt
    output logic                  ALARM_IRQ
);

    logic [6:0]        alarm_value [0:5];
    logic [5:0]        compare_enable;
    logic              alarm_interrupt_enable;
    logic              alarm_flag;
    logic              match_q;
    logic [6:0]        counter_value [0:5];
    logic [5:0]        field_match;
    logic              all_match;
    logic              match_event;
    logic              next_flag;
    logic              ctrl_wr;
    logic              clr_wr;
    logic [7:0]        next_rdata;

    localparam logic [5:0] RST_ENABLES = `RAC_RST_ENABLES;

    // Writable bits of each alarm value field
    function automatic logic [6:0] field_mask(input logic [2:0] sel);
        logic [6:0] m;
        m = 7'h00;
        case (sel)
            rac_pkg::RAC_SEL_SECOND:  m = `RAC_MASK_SECOND;
            rac_pkg::RAC_SEL_MINUTE:  m = `RAC_MASK_MINUTE;
            rac_pkg::RAC_SEL_HOUR:    m = `RAC_MASK_HOUR;
            rac_pkg::RAC_SEL_WEEKDAY: m = `RAC_MASK_WEEKDAY;
            rac_pkg::RAC_SEL_DAY:     m = `RAC_MASK_DAY;
            rac_pkg::RAC_SEL_MONTH:   m = `RAC_MASK_MONTH;
            default:                  m = 7'h00;
        endcase
        return m;
    endfunction

    // Alarm register index from address, 3'b111 when not an alarm
    function automatic logic [2:0] alarm_sel(input logic [3:0] a);
        logic [2:0] s;
        s = 3'b111;
        if (a <= `RAC_OFF_MONTH_ALARM) begin
            s = a[2:0];
        end
        return s;
    endfunction

    assign counter_value[0] = TIME_NOW.second;
    assign counter_value[1] = TIME_NOW.minute;
    assign counter_value[2] = TIME_NOW.hour;
    assign counter_value[3] = TIME_NOW.weekday;
    assign counter_value[4] = TIME_NOW.day;
    assign counter_value[5] = TIME_NOW.month;

    assign ctrl_wr = WR && (ADDR == `RAC_OFF_CONTROL_ONE);
    assign clr_wr  = WR && (ADDR == `RAC_OFF_IRQ_CLEAR);

    // Per-field storage and comparison
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_field
            // Values have no reset at all
            always_ff @(posedge CLK) begin
                if (WR && alarm_sel(ADDR) == 3'(gi)) begin
                    alarm_value[gi] <= WDATA[6:0] & field_mask(3'(gi));
                end
            end

            always_ff @(posedge CLK) begin
                if (RESET) begin
                    compare_enable[gi] <= RST_ENABLES[gi];
                end else if (WR && alarm_sel(ADDR) == 3'(gi)) begin
                    compare_enable[gi] <= WDATA[`RAC_ENABLE_BIT];
                end
            end

            // Disabled fields always count as matching
            assign field_match[gi] = !compare_enable[gi] ||
                (alarm_value[gi] == (counter_value[gi] & field_mask(3'(gi))));
        end
    endgenerate

    assign all_match   = (&field_match) && (|compare_enable);
    assign match_event = all_match && !match_q;

    // Match history, so one match sets the flag once
    always_ff @(posedge CLK) begin
        if (RESET) begin
            match_q <= 1'b0;
        end else begin
            match_q <= all_match;
        end
    end

    // Alarm flag: set beats clear
    always_comb begin
        next_flag = alarm_flag;
        if ((ctrl_wr && !WDATA[`RAC_FLAG_BIT]) ||
            (clr_wr && WDATA[`RAC_IRQ_ALARM_BIT])) begin
            next_flag = 1'b0;
        end
        if (match_event) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            alarm_flag <= `RAC_RST_FLAG;
        end else begin
            alarm_flag <= next_flag;
        end
    end

    // Interrupt enable, also reset by manual reset
    always_ff @(posedge CLK) begin
        if (RESET || MANUAL_RESET) begin
            alarm_interrupt_enable <= `RAC_RST_AIE;
        end else if (ctrl_wr) begin
            alarm_interrupt_enable <= WDATA[`RAC_AIE_BIT];
        end else if (WR && ADDR == `RAC_OFF_IRQ_ENABLE) begin
            alarm_interrupt_enable <= WDATA[`RAC_IRQ_ALARM_BIT];
        end
    end

    // Level interrupt
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ALARM_IRQ <= 1'b0;
        end else begin
            ALARM_IRQ <= alarm_flag && alarm_interrupt_enable;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        if (alarm_sel(ADDR) != 3'b111) begin
            next_rdata[6:0] = alarm_value[alarm_sel(ADDR)];
            next_rdata[`RAC_ENABLE_BIT] = compare_enable[alarm_sel(ADDR)];
        end else if (ADDR == `RAC_OFF_CONTROL_ONE) begin
            next_rdata[`RAC_FLAG_BIT] = alarm_flag;
            next_rdata[`RAC_AIE_BIT]  = alarm_interrupt_enable;
        end else if (ADDR == `RAC_OFF_IRQ_STATUS) begin
            next_rdata[`RAC_IRQ_ALARM_BIT] = alarm_flag;
        end else if (ADDR == `RAC_OFF_IRQ_ENABLE) begin
            next_rdata[`RAC_IRQ_ALARM_BIT] = alarm_interrupt_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence ctrl_clear_s;
        ctrl_wr && !WDATA[`RAC_FLAG_BIT] && !match_event;
    endsequence

    sequence ctrl_keep_s;
        ctrl_wr && WDATA[`RAC_FLAG_BIT] && !match_event && !alarm_flag;
    endsequence

    sequence match_rise_s;
        !match_q && all_match;
    endsequence

    sequence clr_one_s;
        clr_wr && WDATA[`RAC_IRQ_ALARM_BIT] && !match_event;
    endsequence

    sequence flag_hold_s;
        alarm_flag && !ctrl_wr && !clr_wr;
    endsequence

    property reset_enables_p;
        @(posedge CLK) disable iff (1'b0)
        RESET |=> compare_enable == 6'h00;
    endproperty

    enables_reset_a: assert property (reset_enables_p)
        else $error("Enable bits not cleared by reset");

    match_sets_a: assert property (match_rise_s |=> alarm_flag)
        else $error("Match did not set alarm flag");

    no_enable_a: assert property ((compare_enable == 6'h00) && !alarm_flag
        |=> !alarm_flag)
        else $error("Flag set with no field enabled");

    disabled_ignored_a: assert property ((compare_enable == 6'h01) &&
        (alarm_value[0] == (counter_value[0] & `RAC_MASK_SECOND)) && !match_q
        |=> alarm_flag)
        else $error("Disabled fields blocked the match");

    flag_clear_a: assert property (ctrl_clear_s |=> !alarm_flag)
        else $error("Writing zero did not clear flag");

    flag_keep_a: assert property (ctrl_keep_s |=> !alarm_flag)
        else $error("Writing one changed the flag");

    irq_follows_a: assert property (1 |=> ALARM_IRQ ==
        $past(alarm_flag && alarm_interrupt_enable))
        else $error("Interrupt does not follow flag and enable");

    hour_zero_a: assert property (RD && (ADDR == `RAC_OFF_HOUR_ALARM ||
        ADDR == `RAC_OFF_DAY_ALARM) |=> RDATA[6] == 1'b0)
        else $error("Hour or day bit 6 not zero");

    weekday_zero_a: assert property (RD && ADDR == `RAC_OFF_WEEKDAY_ALARM
        |=> RDATA[6:3] == 4'h0)
        else $error("Weekday bits 6 to 3 not zero");

    month_zero_a: assert property (RD && ADDR == `RAC_OFF_MONTH_ALARM
        |=> RDATA[6:5] == 2'h0)
        else $error("Month bits 6 to 5 not zero");

    value_kept_a: assert property (MANUAL_RESET && !WR
        |=> $stable(alarm_value[0]) && $stable(alarm_value[5]))
        else $error("Alarm value lost on manual reset");

    second_store_a: assert property (WR && ADDR == `RAC_OFF_SECOND_ALARM
        |=> alarm_value[0] == $past(WDATA[6:0]))
        else $error("Second alarm value not stored");

    minute_store_a: assert property (WR && ADDR == `RAC_OFF_MINUTE_ALARM
        |=> alarm_value[1] == $past(WDATA[6:0]))
        else $error("Minute alarm value not stored");

    hour_store_a: assert property (WR && ADDR == `RAC_OFF_HOUR_ALARM
        |=> alarm_value[2] == {1'b0, $past(WDATA[5:0])})
        else $error("Hour alarm value not stored");

    weekday_store_a: assert property (WR && ADDR == `RAC_OFF_WEEKDAY_ALARM
        |=> alarm_value[3] == {4'h0, $past(WDATA[2:0])})
        else $error("Weekday alarm value not stored");

    day_store_a: assert property (WR && ADDR == `RAC_OFF_DAY_ALARM
        |=> alarm_value[4] == {1'b0, $past(WDATA[5:0])})
        else $error("Day alarm value not stored");

    month_store_a: assert property (WR && ADDR == `RAC_OFF_MONTH_ALARM
        |=> alarm_value[5] == {2'h0, $past(WDATA[4:0])})
        else $error("Month alarm value not stored");

    rdata_idle_a: assert property (!RD
        |=> RDATA == 8'h00)
        else $error("Read data not zero outside a read");

    irq_reset_a: assert property (@(posedge CLK) disable iff (1'b0) RESET
        |=> !ALARM_IRQ)
        else $error("Interrupt not cleared by reset");

    flag_reset_a: assert property (@(posedge CLK) disable iff (1'b0) RESET
        |=> !alarm_flag)
        else $error("Flag not cleared by reset");

    aie_manual_a: assert property (MANUAL_RESET
        |=> !alarm_interrupt_enable)
        else $error("Interrupt enable kept through manual reset");

    clr_reg_a: assert property (clr_one_s |=> !alarm_flag)
        else $error("Clear register did not clear flag");

    clr_zero_a: assert property (clr_wr && !WDATA[`RAC_IRQ_ALARM_BIT] && alarm_flag
        |=> alarm_flag)
        else $error("Clear register zero changed flag");

    flag_hold_a: assert property (flag_hold_s |=> alarm_flag)
        else $error("Flag dropped without a clear");

    ctrl_one_keeps_a: assert property (ctrl_wr && WDATA[`RAC_FLAG_BIT] && alarm_flag
        |=> alarm_flag)
        else $error("Writing one cleared the flag");

    set_wins_a: assert property (match_event
        |=> alarm_flag)
        else $error("Match event lost against clear");

    no_set_a: assert property (!match_event && !alarm_flag
        |=> !alarm_flag)
        else $error("Flag set without a match");

    match_hist_a: assert property (1
        |=> match_q == $past(all_match))
        else $error("Match history wrong");

    second_enable_a: assert property (WR && ADDR == `RAC_OFF_SECOND_ALARM
        |=> compare_enable[0] == $past(WDATA[`RAC_ENABLE_BIT]))
        else $error("Second enable not stored");

    month_enable_a: assert property (WR && ADDR == `RAC_OFF_MONTH_ALARM
        |=> compare_enable[5] == $past(WDATA[`RAC_ENABLE_BIT]))
        else $error("Month enable not stored");

    status_read_a: assert property (RD && ADDR == `RAC_OFF_IRQ_STATUS
        |=> RDATA == {7'h00, $past(alarm_flag)})
        else $error("Status read wrong");

    unmapped_read_a: assert property (RD && ADDR > `RAC_OFF_IRQ_ENABLE
        |=> RDATA == 8'h00)
        else $error("Unmapped read not zero");

    ctrl_read_a: assert property (RD && ADDR == `RAC_OFF_CONTROL_ONE
        |=> RDATA == {4'h0, $past(alarm_interrupt_enable), 2'h0, $past(alarm_flag)})
        else $error("Control read wrong");

    aie_write_a: assert property (ctrl_wr && !MANUAL_RESET
        |=> alarm_interrupt_enable == $past(WDATA[`RAC_AIE_BIT]))
        else $error("Control write lost interrupt enable");

    irq_enable_write_a: assert property (WR && ADDR == `RAC_OFF_IRQ_ENABLE && !MANUAL_RESET
        |=> alarm_interrupt_enable == $past(WDATA[`RAC_IRQ_ALARM_BIT]))
        else $error("Enable write lost interrupt enable");

    irq_off_a: assert property (!alarm_interrupt_enable
        |=> !ALARM_IRQ)
        else $error("Interrupt raised while disabled");

    second_read_a: assert property (RD && ADDR == `RAC_OFF_SECOND_ALARM
        |=> RDATA == {$past(compare_enable[0]), $past(alarm_value[0])})
        else $error("Second alarm read wrong");

    unmapped_write_a: assert property (WR && ADDR > `RAC_OFF_MONTH_ALARM
        |=> $stable(compare_enable))
        else $error("Enables changed by other write");

endmodule

// ### inc/rac_consts.svh
`ifndef RAC_CONSTS_SVH
`define RAC_CONSTS_SVH

// Register offsets
`define RAC_OFF_SECOND_ALARM  4'h0
`define RAC_OFF_MINUTE_ALARM  4'h1
`define RAC_OFF_HOUR_ALARM    4'h2
`define RAC_OFF_WEEKDAY_ALARM 4'h3
`define RAC_OFF_DAY_ALARM     4'h4
`define RAC_OFF_MONTH_ALARM   4'h5
`define RAC_OFF_CONTROL_ONE   4'h6
`define RAC_OFF_IRQ_STATUS    4'h7
`define RAC_OFF_IRQ_CLEAR     4'h8
`define RAC_OFF_IRQ_ENABLE    4'h9

// Alarm register fields
`define RAC_ENABLE_BIT        7
`define RAC_MASK_SECOND       7'h7f
`define RAC_MASK_MINUTE       7'h7f
`define RAC_MASK_HOUR         7'h3f
`define RAC_MASK_WEEKDAY      7'h07
`define RAC_MASK_DAY          7'h3f
`define RAC_MASK_MONTH        7'h1f

// Control and interrupt fields
`define RAC_FLAG_BIT          0
`define RAC_AIE_BIT           3
`define RAC_IRQ_ALARM_BIT     0

// Reset values
`define RAC_RST_ENABLES       6'h00
`define RAC_RST_AIE           1'h0
`define RAC_RST_FLAG          1'h0

`endif

// ### inc/rac_pkg.sv
package rac_pkg;

    typedef logic [6:0] rac_field_t;

    // Six time counter values, BCD, low-aligned
    typedef struct packed {
        rac_field_t month;
        rac_field_t day;
        rac_field_t weekday;
        rac_field_t hour;
        rac_field_t minute;
        rac_field_t second;
    } rac_time_t;

    typedef enum logic [2:0] {
        RAC_SEL_SECOND  = 3'b000,
        RAC_SEL_MINUTE  = 3'b001,
        RAC_SEL_HOUR    = 3'b010,
        RAC_SEL_WEEKDAY = 3'b011,
        RAC_SEL_DAY     = 3'b100,
        RAC_SEL_MONTH   = 3'b101
    } rac_sel_t;

endpackage

// ### verification/tb_rtc_alarm_compare.sv
`timescale 1ns/10ps
`include "rac_consts.svh"

`define CHK(nm, e, g) check(nm, e, g)

module tb_rtc_alarm_compare;
    logic               clk;
    logic               reset;
    logic               manual_reset;
    logic [3:0]         addr;
    logic [7:0]         wdata;
    logic               wr;
    logic               rd;
    logic [7:0]         rdata;
    rac_pkg::rac_time_t time_now;
    logic               alarm_irq;
    int                 error_cnt;
    int                 n_compared;
    logic [6:0]         av  [6] = '{7'h59, 7'h30, 7'h23, 7'h06, 7'h31, 7'h12};
    logic [6:0]         ov  [6] = '{7'h10, 7'h44, 7'h15, 7'h03, 7'h08, 7'h11};
    logic [6:0]         msk [6] = '{`RAC_MASK_SECOND, `RAC_MASK_MINUTE, `RAC_MASK_HOUR,
                                    `RAC_MASK_WEEKDAY, `RAC_MASK_DAY, `RAC_MASK_MONTH};

    rac_alarm_compare dut (
        .CLK          (clk),
        .RESET        (reset),
        .MANUAL_RESET (manual_reset),
        .ADDR         (addr),
        .WDATA        (wdata),
        .WR           (wr),
        .RD           (rd),
        .RDATA        (rdata),
        .TIME_NOW     (time_now),
        .ALARM_IRQ    (alarm_irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(nm, e, rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Field i of the counters equals its alarm value where m[i] is set
    task automatic set_time(input logic [5:0] m);
        @(posedge clk);
        time_now <= {m[5] ? av[5] : ov[5], m[4] ? av[4] : ov[4], m[3] ? av[3] : ov[3],
                     m[2] ? av[2] : ov[2], m[1] ? av[1] : ov[1], m[0] ? av[0] : ov[0]};
    endtask

    task automatic prog_alarms(input logic [5:0] en);
        for (int i = 0; i < 6; i++) begin
            wr_reg(4'(i), {en[i], av[i]});
        end
    endtask

    task automatic t_fields();
        for (int i = 0; i < 6; i++) begin
            wr_reg(4'(i), 8'hff);
            rd_chk("alarm field", 4'(i), {1'b1, msk[i]});
        end
        wr_reg(4'ha, 8'hff);
        rd_chk("unmapped", 4'ha, 8'h00);
        $display("test fields done");
    endtask

    task automatic t_single();
        for (int i = 0; i < 6; i++) begin
            set_time(6'h00);
            prog_alarms(6'(1 << i));
            set_time(~6'(1 << i));
            wait_cyc(3);
            rd_chk("flag off", `RAC_OFF_IRQ_STATUS, 8'h00);
            set_time(6'(1 << i));
            wait_cyc(3);
            rd_chk("flag single", `RAC_OFF_IRQ_STATUS, 8'h01);
            wr_reg(`RAC_OFF_IRQ_CLEAR, 8'h01);
            rd_chk("flag cleared", `RAC_OFF_IRQ_STATUS, 8'h00);
        end
        set_time(6'h00);
        $display("test single done");
    endtask

    task automatic t_all();
        prog_alarms(6'h3f);
        set_time(6'h1f);
        wait_cyc(3);
        rd_chk("flag partial", `RAC_OFF_IRQ_STATUS, 8'h00);
        set_time(6'h3f);
        wait_cyc(3);
        rd_chk("flag all", `RAC_OFF_IRQ_STATUS, 8'h01);
        wr_reg(`RAC_OFF_IRQ_CLEAR, 8'h01);
        set_time(6'h00);
        prog_alarms(6'h00);
        set_time(6'h3f);
        wait_cyc(3);
        rd_chk("flag none", `RAC_OFF_IRQ_STATUS, 8'h00);
        set_time(6'h00);
        $display("test all done");
    endtask

    task automatic t_irq();
        prog_alarms(6'h01);
        wr_reg(`RAC_OFF_IRQ_ENABLE, 8'h01);
        set_time(6'h01);
        wait_cyc(3);
        `CHK("irq on", 8'h01, {7'h00, alarm_irq});
        wr_reg(`RAC_OFF_IRQ_ENABLE, 8'h00);
        wait_cyc(2);
        `CHK("irq masked", 8'h00, {7'h00, alarm_irq});
        wr_reg(`RAC_OFF_CONTROL_ONE, 8'h09);
        wait_cyc(2);
        `CHK("irq flag kept", 8'h01, {7'h00, alarm_irq});
        wr_reg(`RAC_OFF_CONTROL_ONE, 8'h08);
        wait_cyc(3);
        `CHK("irq flag clear", 8'h00, {7'h00, alarm_irq});
        rd_chk("flag stays clear", `RAC_OFF_IRQ_STATUS, 8'h00);
        set_time(6'h00);
        $display("test irq done");
    endtask

    task automatic t_reset();
        prog_alarms(6'h3f);
        wr_reg(`RAC_OFF_IRQ_ENABLE, 8'h01);
        @(posedge clk);
        manual_reset <= 1'b1;
        @(posedge clk);
        manual_reset <= 1'b0;
        rd_chk("irq enable", `RAC_OFF_IRQ_ENABLE, 8'h00);
        rd_chk("manual keep", 4'h0, {1'b1, av[0]});
        @(posedge clk);
        reset <= 1'b1;
        wait_cyc(2);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd_chk("after reset", 4'(i), {1'b0, av[i]});
        end
        $display("test reset done");
    endtask

    initial begin
        reset        = 1'b1;
        manual_reset = 1'b0;
        addr         = 4'h0;
        wdata        = 8'h00;
        wr           = 1'b0;
        rd           = 1'b0;
        time_now     = '0;
        error_cnt    = 0;
        n_compared   = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_fields();
        t_single();
        t_all();
        t_irq();
        t_reset();
        stop_test();
    end

    initial begin
        #(50 * 20000);
        error_cnt++;
        stop_test();
    end
endmodule
